// *** design/gom_pin7_mux.sv ***
// Output source multiplexer and drive control for general-purpose pin 7.
// Assumes all inputs are synchronous to clk_in; registers reached over a strobe port.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module gom_pin7_mux (
   input  wire logic                                     clk_in,
   input  wire logic                                     rst_in,
   input  wire gom_pkg::gom_bus_req_t                    bus_in,
   output logic [gom_pkg::DATA_W-1:0]                    rdata_out,
   input  wire gom_pkg::gom_rx_t [gom_pkg::NUM_RX-1:0]   rx_in,
   input  wire logic [gom_pkg::NUM_RX-1:0]               rx_enable_in,
   input  wire gom_pkg::gom_tx_t [gom_pkg::NUM_TX-1:0]   tx_in,
   input  wire logic [gom_pkg::FS_MODE_W-1:0]            fs_mode_in,
   input  wire logic                                     fs_internal_in,
   input  wire logic [gom_pkg::NUM_GPIO-1:0]             gpio_in,
   output logic                                          pin_out,
   output logic                                          pin_oe_out
);
   import gom_pkg::*;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // AND over the masked members; an empty mask gives low
   function automatic logic mask_and(input logic [NUM_RX-1:0] v, input logic [NUM_RX-1:0] m);
      mask_and = (|m) & (&(v | ~m));
   endfunction

   function automatic logic mask_or(input logic [NUM_RX-1:0] v, input logic [NUM_RX-1:0] m);
      mask_or = |(v & m);
   endfunction

   function automatic logic rx_pick(input gom_rx_t rx, input logic [2:0] sel);
      rx_pick = 1'b0;
      unique case (sel)
         SEL_RX_PIN0, SEL_RX_PIN1,
         SEL_RX_PIN2, SEL_RX_PIN3 : rx_pick = rx.remote_pin[sel[1:0]];
         SEL_RX_LOCK              : rx_pick = rx.lock;
         SEL_RX_PASS              : rx_pick = rx.pass;
         SEL_RX_FV                : rx_pick = rx.frame_valid;
         SEL_RX_LV                : rx_pick = rx.line_valid;
      endcase
   endfunction

   function automatic logic tx_pick(input gom_tx_t tx, input logic [NUM_RX-1:0] pass_v,
                                    input logic [2:0] sel);
      tx_pick = 1'b0;
      unique case (sel)
         SEL_TX_PASS_AND : tx_pick = mask_and(pass_v, tx.rx_select);
         SEL_TX_PASS_OR  : tx_pick = mask_or(pass_v, tx.rx_select);
         SEL_TX_FV       : tx_pick = tx.frame_valid;
         SEL_TX_LV       : tx_pick = tx.line_valid;
         SEL_TX_SYNC     : tx_pick = tx.synced;
         SEL_TX_IRQ      : tx_pick = tx.irq;
         default         : tx_pick = 1'b0;
      endcase
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   gom_state_t              state_q;
   gom_state_t              state_d;
   logic [NUM_RX-1:0]       lock_v;
   logic [NUM_RX-1:0]       pass_v;
   logic                    fs_lvl;
   logic                    sel_lvl;
   logic [DATA_W-1:0]       status_val;

   // ****************************************************************
   // Per-port status vectors
   // ****************************************************************
   for (genvar i = 0; i < NUM_RX; i++) begin : g_rx
      assign lock_v[i] = rx_in[i].lock;
      assign pass_v[i] = rx_in[i].pass;
   end

   gom_fsync_sel u_fsync (
      .fs_mode_in     (fs_mode_in),
      .fs_internal_in (fs_internal_in),
      .gpio_in        (gpio_in),
      .fs_out         (fs_lvl)
   );

   // ****************************************************************
   // Source selection
   // ****************************************************************
   always_comb begin
      sel_lvl = 1'b0;
      unique case (state_q.ctrl.src)
         SRC_RX0, SRC_RX1,
         SRC_RX2, SRC_RX3 : begin
            sel_lvl = rx_pick(rx_in[state_q.ctrl.src[1:0]], state_q.ctrl.sel);
         end
         SRC_STATUS : begin
            unique case (state_q.ctrl.sel)
               SEL_ST_VALUE   : sel_lvl = state_q.ctrl.val;
               SEL_ST_LOCK_OR : sel_lvl = mask_or(lock_v, rx_enable_in);
               SEL_ST_PASS_A,
               SEL_ST_PASS_B  : sel_lvl = mask_and(pass_v, rx_enable_in);
               SEL_ST_FSYNC   : sel_lvl = fs_lvl;
               default        : sel_lvl = 1'b0;
            endcase
         end
         SRC_RSVD : begin
            sel_lvl = 1'b0;
         end
         SRC_TX0, SRC_TX1 : begin
            sel_lvl = tx_pick(tx_in[state_q.ctrl.src[0]], pass_v, state_q.ctrl.sel);
         end
      endcase
   end

   // ****************************************************************
   // Register port and pin drive
   // ****************************************************************
   always_comb begin
      status_val               = READ_ZERO;
      status_val[STAT_PIN_BIT] = state_q.pin;
      status_val[STAT_OE_BIT]  = state_q.oe;
      status_val[STAT_FS_BIT]  = fs_lvl;

      state_d       = state_q;
      state_d.rdata = READ_ZERO;
      if (bus_in.wr && (bus_in.addr == PIN7_CTRL_ADDR)) begin
         state_d.ctrl = gom_ctrl_t'(bus_in.wdata);
      end
      if (bus_in.rd) begin
         if (bus_in.addr == PIN7_CTRL_ADDR) begin
            state_d.rdata = state_q.ctrl;
         end else if (bus_in.addr == PIN7_STATUS_ADDR) begin
            state_d.rdata = status_val;
         end
      end
      // Driver off holds the data line low so nothing stale appears when re-enabled
      state_d.oe  = state_q.ctrl.en;
      state_d.pin = state_q.ctrl.en & sel_lvl;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q       <= '0;
         state_q.ctrl  <= gom_ctrl_t'(PIN7_CTRL_RESET);
      end else begin
         state_q <= state_d;
      end
   end

   assign rdata_out  = state_q.rdata;
   assign pin_out    = state_q.pin;
   assign pin_oe_out = state_q.oe;

endmodule

`default_nettype wire

// *** common/gom_pkg.sv ***
// Constants and carrier types for the pin 7 output source multiplexer.
// Assumes a single device clock and a plain strobe-based register port.
package gom_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned NUM_RX     = 4;
   localparam int unsigned NUM_TX     = 2;
   localparam int unsigned NUM_REMOTE = 4;
   localparam int unsigned NUM_GPIO   = 8;
   localparam int unsigned FS_MODE_W  = 4;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [ADDR_W-1:0] PIN7_CTRL_ADDR   = 8'h17;
   localparam logic [ADDR_W-1:0] PIN7_STATUS_ADDR = 8'h80;
   localparam logic [DATA_W-1:0] PIN7_CTRL_RESET  = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO        = 8'h00;

   // Status register bit positions
   localparam int unsigned STAT_PIN_BIT = 0;
   localparam int unsigned STAT_OE_BIT  = 1;
   localparam int unsigned STAT_FS_BIT  = 2;

   // ****************************************************************
   // Source field codes
   // ****************************************************************
   localparam logic [2:0] SRC_RX0    = 3'h0;
   localparam logic [2:0] SRC_RX1    = 3'h1;
   localparam logic [2:0] SRC_RX2    = 3'h2;
   localparam logic [2:0] SRC_RX3    = 3'h3;
   localparam logic [2:0] SRC_STATUS = 3'h4;
   localparam logic [2:0] SRC_RSVD   = 3'h5;
   localparam logic [2:0] SRC_TX0    = 3'h6;
   localparam logic [2:0] SRC_TX1    = 3'h7;

   // ****************************************************************
   // Signal selector codes
   // ****************************************************************
   localparam logic [2:0] SEL_RX_PIN0 = 3'h0;
   localparam logic [2:0] SEL_RX_PIN1 = 3'h1;
   localparam logic [2:0] SEL_RX_PIN2 = 3'h2;
   localparam logic [2:0] SEL_RX_PIN3 = 3'h3;
   localparam logic [2:0] SEL_RX_LOCK = 3'h4;
   localparam logic [2:0] SEL_RX_PASS = 3'h5;
   localparam logic [2:0] SEL_RX_FV   = 3'h6;
   localparam logic [2:0] SEL_RX_LV   = 3'h7;

   localparam logic [2:0] SEL_ST_VALUE    = 3'h0;
   localparam logic [2:0] SEL_ST_LOCK_OR  = 3'h1;
   localparam logic [2:0] SEL_ST_PASS_A   = 3'h2;
   localparam logic [2:0] SEL_ST_PASS_B   = 3'h3;
   localparam logic [2:0] SEL_ST_FSYNC    = 3'h4;

   localparam logic [2:0] SEL_TX_PASS_AND = 3'h0;
   localparam logic [2:0] SEL_TX_PASS_OR  = 3'h1;
   localparam logic [2:0] SEL_TX_FV       = 3'h2;
   localparam logic [2:0] SEL_TX_LV       = 3'h3;
   localparam logic [2:0] SEL_TX_SYNC     = 3'h4;
   localparam logic [2:0] SEL_TX_IRQ      = 3'h5;

   // Frame-sync mode: top bit set selects an external pin
   localparam int unsigned FS_MODE_EXT_BIT = 3;

   // ****************************************************************
   // Carrier types
   // ****************************************************************
   typedef struct packed {
      logic [2:0] sel;
      logic [2:0] src;
      logic       val;
      logic       en;
   } gom_ctrl_t;

   typedef struct packed {
      logic [NUM_REMOTE-1:0] remote_pin;
      logic                  lock;
      logic                  pass;
      logic                  frame_valid;
      logic                  line_valid;
   } gom_rx_t;

   typedef struct packed {
      logic [NUM_RX-1:0] rx_select;
      logic              frame_valid;
      logic              line_valid;
      logic              synced;
      logic              irq;
   } gom_tx_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } gom_bus_req_t;

   typedef struct packed {
      gom_ctrl_t         ctrl;
      logic              pin;
      logic              oe;
      logic [DATA_W-1:0] rdata;
   } gom_state_t;

endpackage

// *** design/gom_fsync_sel.sv ***
// Frame-sync source selector for the pin 7 output multiplexer.
// Assumes the internal generator output and the pins are synchronous to the device clock.
`timescale 1ns/10ps
`default_nettype none

module gom_fsync_sel (
   input  wire logic [gom_pkg::FS_MODE_W-1:0] fs_mode_in,
   input  wire logic                          fs_internal_in,
   input  wire logic [gom_pkg::NUM_GPIO-1:0]  gpio_in,
   output logic                               fs_out
);
   import gom_pkg::*;

   // ****************************************************************
   // Internal generator or one of the external pins
   // ****************************************************************
   always_comb begin
      if (fs_mode_in[FS_MODE_EXT_BIT]) begin
         fs_out = gpio_in[fs_mode_in[FS_MODE_EXT_BIT-1:0]];
      end else begin
         fs_out = fs_internal_in;
      end
   end

endmodule

`default_nettype wire

// *** tb/gom_pin7_monitor.sv ***
// Checker for the pin 7 output multiplexer.
// Sees only the top ports; bound at the foot of this file.
`timescale 1ns/10ps
`default_nettype none
module gom_pin7_monitor (
   input wire logic                      clk_in,
   input wire logic                      rst_in,
   input wire gom_pkg::gom_bus_req_t     bus_in,
   input wire logic [7:0]                rdata_out,
   input wire gom_pkg::gom_rx_t [3:0]    rx_in,
   input wire logic [3:0]                rx_enable_in,
   input wire gom_pkg::gom_tx_t [1:0]    tx_in,
   input wire logic [3:0]                fs_mode_in,
   input wire logic                      fs_internal_in,
   input wire logic [7:0]                gpio_in,
   input wire logic                      pin_out,
   input wire logic                      pin_oe_out
);
   import gom_pkg::*;
   gom_ctrl_t  c_q;
   gom_rx_t    r;
   gom_tx_t    t;
   logic [3:0] lk;
   logic [3:0] ps;
   logic       e_q;
   logic       x_q;
   logic       s;
   logic       fs;
   // ****************************************************************
   // Reference selection, one cycle ahead of the pin
   // ****************************************************************
   always_comb begin
      r = rx_in[c_q.src[1:0]];
      t = tx_in[c_q.src[0]];
      for (int i = 0; i < 4; i++) begin
         lk[i] = rx_in[i].lock;
         ps[i] = rx_in[i].pass;
      end
      fs = fs_mode_in[3] ? gpio_in[fs_mode_in[2:0]] : fs_internal_in;
      s = 1'b0;
      case (c_q.src)
         3'h4: case (c_q.sel)
            3'h0: s = c_q.val;
            3'h1: s = |(lk & rx_enable_in);
            3'h2, 3'h3: s = (rx_enable_in != 4'h0) && ((ps | ~rx_enable_in) == 4'hf);
            3'h4: s = fs;
            default: s = 1'b0;
         endcase
         3'h5: s = 1'b0;
         3'h6, 3'h7: case (c_q.sel)
            3'h0: s = (t.rx_select != 4'h0) && ((ps | ~t.rx_select) == 4'hf);
            3'h1: s = |(ps & t.rx_select);
            3'h2, 3'h3, 3'h4, 3'h5: s = t[5 - c_q.sel];
            default: s = 1'b0;
         endcase
         default: s = c_q.sel[2] ? r[3 - c_q.sel[1:0]] : r.remote_pin[c_q.sel[1:0]];
      endcase
   end
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         c_q <= '0;
         e_q <= 1'b0;
         x_q <= 1'b0;
      end else begin
         if (bus_in.wr && bus_in.addr == 8'h17)
            c_q <= bus_in.wdata;
         e_q <= c_q.en;
         x_q <= s;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_oe_tracks_en: assert property (pin_oe_out == e_q)
      else $error("pin enable differs from control");
   a_off_drives_low: assert property (!pin_oe_out |-> !pin_out)
      else $error("pin high while driver off");
   a_rx_source_map: assert property ($past(!c_q.src[2]) |-> pin_out == (e_q & x_q))
      else $error("rx source level wrong");
   a_status_map: assert property ($past(c_q.src == 3'h4) |-> pin_out == (e_q & x_q))
      else $error("status source level wrong");
   a_tx_source_map: assert property ($past(c_q.src[2:1] == 2'b11) |-> pin_out == (e_q & x_q))
      else $error("tx source level wrong");
   a_value_drive: assert property ((c_q[7:2] == 6'h04 && c_q.en) |=> pin_out == $past(c_q.val))
      else $error("value bit not driven");
   a_fsync_pick: assert property ((c_q[7:2] == 6'h24 && c_q.en) |=> pin_out == $past(fs))
      else $error("frame sync level not driven");
   a_reserved_low: assert property ($past(c_q.src == 3'h5 || (c_q.src == 3'h4 && c_q.sel > 3'h4)
      || (c_q.src[2:1] == 2'b11 && c_q.sel > 3'h5)) |-> !pin_out) else $error("reserved code not low");
   a_read_answer: assert property ((bus_in.rd && bus_in.addr == 8'h17) |=> rdata_out == $past(c_q))
      else $error("control read back wrong");
   a_rdata_idle: assert property (!$past(bus_in.rd) |-> rdata_out == 8'h00)
      else $error("read data outside answer cycle");
endmodule
bind gom_pin7_mux gom_pin7_monitor gom_pin7_monitor_i (.clk_in, .rst_in, .bus_in, .rdata_out, .rx_in,
   .rx_enable_in, .tx_in, .fs_mode_in, .fs_internal_in, .gpio_in, .pin_out, .pin_oe_out);
`default_nettype wire

// *** tb/gom_board.sv ***
// Board logic reading pin 7.
// A pull-down holds the line low while the pin is not driven.
`timescale 1ns/10ps
`default_nettype none
module gom_board (
   input  wire logic pin_in,
   input  wire logic oe_in,
   output logic      level_out
);
   assign level_out = oe_in ? pin_in : 1'b0;
endmodule
`default_nettype wire

// *** tb/gom_pin7_mux_tb_top.sv ***
// Testbench for the pin 7 output multiplexer.
// Drives the strobe register port and status inputs; reads the pin through the board model.
`timescale 1ns/10ps
`default_nettype none
module gom_pin7_mux_tb_top;
   import gom_pkg::*;
   logic          clk_in = 1'b0;
   logic          rst_in = 1'b1;
   gom_bus_req_t  bus = '0;
   gom_rx_t [3:0] rx = 32'h08400000;
   gom_tx_t [1:0] tx = 16'h0100;
   logic [3:0]    rx_en = 4'h8;
   logic [3:0]    fs_mode = 4'hb;
   logic [7:0]    gpio = 8'h08;
   logic          fs_int = 1'b0;
   logic [7:0]    rdata;
   logic          pin;
   logic          oe;
   logic          lvl;
   int            n_mismatch = 0;
   int            comparisons = 0;
   int            cyc = 0;
   logic [7:0]    cw [10] = '{8'h13, 8'h11, 8'h12, 8'h17, 8'h49, 8'h69, 8'hbd, 8'hdd, 8'h91, 8'h31};
   logic          pw [10] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   gom_pin7_mux gom_pin7_mux_i (.clk_in, .rst_in, .bus_in(bus), .rdata_out(rdata), .rx_in(rx),
      .rx_enable_in(rx_en), .tx_in(tx), .fs_mode_in(fs_mode), .fs_internal_in(fs_int), .gpio_in(gpio),
      .pin_out(pin), .pin_oe_out(oe));
   gom_board gom_board_i (.pin_in(pin), .oe_in(oe), .level_out(lvl));
   always #25 clk_in = ~clk_in;
   // ****************************************************************
   // Checks and bus tasks
   // ****************************************************************
   task automatic finish_test();
      $display("TB: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk_in);
      bus.wr <= 1'b0;
      // One idle edge so the strobe is never driven twice in one step
      @(posedge clk_in);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk_in);
      bus.rd <= 1'b0;
      @(negedge clk_in);
      chk("rdata", rdata, e);
      @(posedge clk_in);
   endtask
   task automatic pchk(input logic e_oe, input logic e_pin);
      @(posedge clk_in);
      @(negedge clk_in);
      chk("pin_oe", {7'h0, oe}, {7'h0, e_oe});
      chk("pin", {7'h0, lvl}, {7'h0, e_pin});
      @(posedge clk_in);
   endtask
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         finish_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(8'h17, 8'h00);
      wr(8'h17, 8'ha5);
      wr(8'h5a, 8'hff);
      rd(8'h17, 8'ha5);
      rd(8'h33, 8'h00);
      for (int k = 0; k < 10; k++) begin
         wr(8'h17, cw[k]);
         pchk(cw[k][0], pw[k]);
      end
      rx_en <= 4'h7;
      pchk(1'b1, 1'b0);
      wr(8'h17, 8'h13);
      pchk(1'b1, 1'b1);
      rd(8'h80, 8'h07);
      fs_mode <= 4'h3;
      rd(8'h80, 8'h03);
      fs_int <= 1'b1;
      rd(8'h80, 8'h07);
      for (int p = 0; p < 4; p++) begin
         rx <= p[0] ? 32'h3c5a96f1 : 32'hc3a5690e;
         tx <= p[0] ? 16'h5ac3 : 16'ha53c;
         rx_en <= p[1] ? 4'h6 : 4'hf;
         fs_mode <= {p[1], 3'h3};
         fs_int <= p[0];
         for (int i = 0; i < 64; i++)
            wr(8'h17, {i[5:0], 1'b1, p[0]});
      end
      rst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
      rd(8'h17, 8'h00);
      pchk(1'b0, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
